// *** rtl/orient_cfg.svh ***
/*
  register offsets, field positions, reset values and angle limits of the
  orientation settle and tilt threshold block.
  assumes: included by its bare name, after the package, before any module.
*/
`ifndef ORIENT_CFG_SVH
`define ORIENT_CFG_SVH

// ==========================================================
// register offsets
`define OFS_RESULT 8'h28
`define OFS_SETUP 8'h29
`define OFS_SETTLE 8'h2a
`define OFS_TILT 8'h2b
`define OFS_INT_STATUS 8'h30
`define OFS_INT_MASK 8'h31

// ==========================================================
// field positions
`define RESULT_FLAG_BIT 7
`define RESULT_LO_BIT 6
`define SETUP_MODE_BIT 7
`define SETUP_EN_BIT 6
`define INT_CHANGE_BIT 0

// ==========================================================
// reset values
`define SETTLE_RESET 8'h00
`define TILT_RESET 8'h44
`define SETUP_MODE_RESET 1'b1
`define SETUP_EN_RESET 1'b0

// ==========================================================
// back/front limits in degrees: front below base - 5*code, back above base + 5*code
`define BF_FRONT_BASE 9'h050
`define BF_BACK_BASE 9'h064
`define BF_STEP 9'h005
`define FULL_TURN 9'h168

// ==========================================================
// z lockout angles in tenths of a degree, codes 000 to 111
`define ZLOCK_0 10'h088
`define ZLOCK_1 10'h0ab
`define ZLOCK_2 10'h0cf
`define ZLOCK_3 10'h0f4
`define ZLOCK_4 10'h119
`define ZLOCK_5 10'h140
`define ZLOCK_6 10'h169
`define ZLOCK_7 10'h194

`endif

// *** rtl/orient_pkg.sv ***
/*
  types of the orientation settle and tilt threshold block.
  assumes: compiled before the design module.
*/
package orient_pkg;

  // ==========================================================
  // one classified orientation
  typedef struct packed {
    logic lo;
    logic [1:0] lapo;
    logic bafro;
  } orient_t;

  // ==========================================================
  // all state of the block
  typedef struct packed {
    logic settle_counter_mode;
    logic orientation_function_on;
    logic [7:0] orientation_settle_count;
    logic [1:0] back_front_trip_sel;
    logic [2:0] z_lockout_sel;
    orient_t stable;
    orient_t prev;
    logic [7:0] settle_cnt;
    logic first_pending;
    logic orientation_changed_flag;
    logic active_d;
    logic sleep_d;
    logic int_status;
    logic int_mask;
    logic [7:0] rdata;
  } state_t;

endpackage

// *** rtl/orientation_settle.sv ***
/*
  orientation settle counter, back/front trip and z lockout classification,
  with a small register port and a level interrupt.
  assumes: sample_tick pulses once per output sample period of the mode in
  use (selected rate in low power and high performance, effective rate in
  flexible performance); angle and landscape/portrait inputs are valid with
  the tick; all inputs are synchronous to clk.
*/
`timescale 1ns/10ps
`include "orient_cfg.svh"

// How it works
// - flag rises only after a new orientation held settle-count sample periods
// - counter steps once per sample tick of the active mode's rate
// - counter clears entering or leaving active and on any wake/sleep change
// - above 1.25 g on any axis counter and orientation hold still
// - counter-mode bit picks the reaction to a changed orientation
// - mode 1 clears counter on mismatch, mode 0 decrements; mode resets to 1
// - back/front trip field bits 7:6, reset 01, 65 to 80 degrees
// - code 00: front below 80 or above 280, back strictly 100 to 260
// - code 01: front below 75 or above 285, back strictly 105 to 255
// - codes 10/11: front 70/290 and 65/295, back 110-250 and 115-245
// - z lockout field bits 2:0, reset 100 meaning 28.1 degrees
// - lockout codes give 13.6 up to 40.4 degrees in eight steps
// - flag sets on first detection after activation and any change; read clears
// - detection stays off until the enable bit is set; enable resets off
module orientation_settle (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // operating state and sampling
  input wire logic sample_tick,
  input wire logic active,
  input wire logic auto_sleep,
  input wire logic high_g,
  // measured angles and landscape/portrait class
  input wire logic [8:0] z_angle,
  input wire logic [9:0] z_tilt_tenths,
  input wire logic [1:0] lapo_class,
  // results
  output logic orientation_changed_flag,
  output logic lockout,
  output logic [1:0] lapo,
  output logic back_facing,
  output logic irq
);

  // ==========================================================
  // state
  orient_pkg::state_t state;
  orient_pkg::state_t next_state;

  // ==========================================================
  // z lockout angles, one comparator per code
  logic [9:0] zlock_table [8];
  logic [7:0] below_limit;

  always_comb begin
    zlock_table[0] = `ZLOCK_0;
    zlock_table[1] = `ZLOCK_1;
    zlock_table[2] = `ZLOCK_2;
    zlock_table[3] = `ZLOCK_3;
    zlock_table[4] = `ZLOCK_4;
    zlock_table[5] = `ZLOCK_5;
    zlock_table[6] = `ZLOCK_6;
    zlock_table[7] = `ZLOCK_7;
  end

  // all eight compare in parallel, so a new code takes effect at the next sample
  for (genvar gi = 0; gi < 8; gi++) begin : g_zlock
    assign below_limit[gi] = z_tilt_tenths < zlock_table[gi];
  end

  // ==========================================================
  // classification of the current sample
  logic [8:0] bf_offset;
  logic [8:0] front_lo;
  logic [8:0] front_hi;
  logic [8:0] back_lo;
  logic [8:0] back_hi;
  logic is_front;
  logic is_back;
  logic is_locked;
  orient_pkg::orient_t cand;

  always_comb begin
    bf_offset = 9'(state.back_front_trip_sel) * `BF_STEP;
    front_lo = `BF_FRONT_BASE - bf_offset;
    front_hi = `FULL_TURN - front_lo;
    back_lo = `BF_BACK_BASE + bf_offset;
    back_hi = `FULL_TURN - back_lo;
    is_front = (z_angle < front_lo) || (z_angle > front_hi);
    is_back = (z_angle > back_lo) && (z_angle < back_hi);
    // limits are symmetric about 180 degrees, so each high edge is 360 minus its low edge
    is_locked = below_limit[state.z_lockout_sel];
    cand.lo = is_locked;
    // in lockout the landscape/portrait state is kept
    cand.lapo = is_locked ? state.prev.lapo : lapo_class;
    // between the two bands the last face is kept
    if (is_back) begin
      cand.bafro = 1'b1;
    end else if (is_front) begin
      cand.bafro = 1'b0;
    end else begin
      cand.bafro = state.prev.bafro;
    end
  end

  // ==========================================================
  // register decode
  logic wr_setup;
  logic wr_settle;
  logic wr_tilt;
  logic wr_int_status;
  logic wr_int_mask;
  logic rd_result;
  logic [7:0] read_mux;
  logic [7:0] result_byte;
  logic [7:0] setup_byte;
  logic [7:0] tilt_byte;
  logic [7:0] int_status_byte;
  logic [7:0] int_mask_byte;

  // ==========================================================
  // register images, reserved bits read as zero
  always_comb begin
    result_byte = 8'h00;
    result_byte[`RESULT_FLAG_BIT] = state.orientation_changed_flag;
    result_byte[`RESULT_LO_BIT] = state.stable.lo;
    result_byte[2:1] = state.stable.lapo;
    result_byte[0] = state.stable.bafro;
    setup_byte = 8'h00;
    setup_byte[`SETUP_MODE_BIT] = state.settle_counter_mode;
    setup_byte[`SETUP_EN_BIT] = state.orientation_function_on;
    tilt_byte = 8'h00;
    tilt_byte[7:6] = state.back_front_trip_sel;
    tilt_byte[2:0] = state.z_lockout_sel;
    int_status_byte = 8'h00;
    int_status_byte[`INT_CHANGE_BIT] = state.int_status;
    int_mask_byte = 8'h00;
    int_mask_byte[`INT_CHANGE_BIT] = state.int_mask;
  end

  always_comb begin
    wr_setup = wr && (addr == `OFS_SETUP);
    wr_settle = wr && (addr == `OFS_SETTLE);
    wr_tilt = wr && (addr == `OFS_TILT);
    wr_int_status = wr && (addr == `OFS_INT_STATUS);
    wr_int_mask = wr && (addr == `OFS_INT_MASK);
    rd_result = rd && (addr == `OFS_RESULT);
    read_mux = 8'h00;
    unique case (addr)
      `OFS_RESULT: begin
        read_mux = result_byte;
      end
      `OFS_SETUP: begin
        read_mux = setup_byte;
      end
      `OFS_SETTLE: begin
        read_mux = state.orientation_settle_count;
      end
      `OFS_TILT: begin
        read_mux = tilt_byte;
      end
      `OFS_INT_STATUS: begin
        read_mux = int_status_byte;
      end
      `OFS_INT_MASK: begin
        read_mux = int_mask_byte;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // settle counter and reporting
  logic enter_active;
  logic leave_active;
  logic sleep_change;
  logic state_change;
  logic run;
  logic mismatch;
  logic at_floor;
  logic at_ceiling;
  logic [7:0] cnt_inc;
  logic [7:0] cnt_dec;
  logic [7:0] cnt_step;
  logic new_face;
  logic report;
  logic int_set;
  logic int_clear;
  logic flag_clear;

  // ==========================================================
  // operating state transitions that restart the settle count
  always_comb begin
    enter_active = active && !state.active_d;
    leave_active = !active && state.active_d;
    sleep_change = auto_sleep != state.sleep_d;
    state_change = enter_active || leave_active || sleep_change;
    // a tick in a transition cycle is dropped, so no count straddles two states
    run = sample_tick && active && state.orientation_function_on && !high_g;
  end

  // ==========================================================
  // counter step for one sample
  always_comb begin
    mismatch = cand != state.prev;
    at_floor = state.settle_cnt == 8'h00;
    at_ceiling = state.settle_cnt == 8'hff;
    // saturate rather than wrap, so a long hold never looks like a fresh start
    cnt_inc = at_ceiling ? state.settle_cnt : state.settle_cnt + 8'h01;
    cnt_dec = at_floor ? state.settle_cnt : state.settle_cnt - 8'h01;
    if (!mismatch) begin
      cnt_step = cnt_inc;
    end else if (state.settle_counter_mode) begin
      cnt_step = 8'h00;
    end else begin
      cnt_step = cnt_dec;
    end
    new_face = (cand != state.stable) || state.first_pending;
    // threshold read at the sample itself
    report = !mismatch && (cnt_step >= state.orientation_settle_count) &&
             new_face;
  end

  // ==========================================================
  // event and clear strobes of the status bits
  always_comb begin
    int_clear = wr_int_status && wdata[`INT_CHANGE_BIT];
    flag_clear = rd_result;
    // applied after the clears, so a report in the same cycle wins
    int_set = run && !state_change && report;
  end

  always_comb begin
    next_state = state;
    next_state.active_d = active;
    next_state.sleep_d = auto_sleep;
    if (wr_setup) begin
      next_state.settle_counter_mode = wdata[`SETUP_MODE_BIT];
      next_state.orientation_function_on = wdata[`SETUP_EN_BIT];
    end
    if (wr_settle) begin
      next_state.orientation_settle_count = wdata;
    end
    if (wr_tilt) begin
      next_state.back_front_trip_sel = wdata[7:6];
      next_state.z_lockout_sel = wdata[2:0];
    end
    if (wr_int_mask) begin
      next_state.int_mask = wdata[`INT_CHANGE_BIT];
    end
    if (int_clear) begin
      next_state.int_status = 1'b0;
    end
    if (flag_clear) begin
      next_state.orientation_changed_flag = 1'b0;
    end
    // counter and orientation are frozen while high_g holds run low
    if (state_change) begin
      next_state.settle_cnt = 8'h00;
      if (enter_active) begin
        next_state.first_pending = 1'b1;
        next_state.stable = '0;
        next_state.prev = '0;
      end
    end else if (run) begin
      next_state.settle_cnt = cnt_step;
      next_state.prev = cand;
      if (report) begin
        next_state.stable = cand;
        next_state.first_pending = 1'b0;
        next_state.orientation_changed_flag = 1'b1;
      end
    end
    if (int_set) begin
      next_state.int_status = 1'b1;
    end
    // read data is zero outside its answer cycle, so a shared bus needs no gating
    next_state.rdata = rd ? read_mux : 8'h00;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    // reset does not wait for ce, so a frozen block can still be brought up
    if (!rst_n) begin
      state <= '0;
      state.settle_counter_mode <= `SETUP_MODE_RESET;
      state.orientation_function_on <= `SETUP_EN_RESET;
      state.orientation_settle_count <= `SETTLE_RESET;
      state.back_front_trip_sel <= 2'(`TILT_RESET >> 6);
      state.z_lockout_sel <= 3'(`TILT_RESET);
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    rdata = state.rdata;
    orientation_changed_flag = state.orientation_changed_flag;
    lockout = state.stable.lo;
    lapo = state.stable.lapo;
    back_facing = state.stable.bafro;
    irq = state.int_status && state.int_mask;
  end

endmodule

// *** verif/orientation_settle_sva.sv ***
/*
  checker of the orientation settle block, watching its ports only.
  assumes: bound to orientation_settle from the testbench top file.
*/
`timescale 1ns/10ps
module orientation_settle_sva (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // state and sampling
  input wire logic sample_tick,
  input wire logic active,
  input wire logic auto_sleep,
  input wire logic high_g,
  // angles and class
  input wire logic [8:0] z_angle,
  input wire logic [9:0] z_tilt_tenths,
  input wire logic [1:0] lapo_class,
  // results
  input wire logic orientation_changed_flag,
  input wire logic lockout,
  input wire logic [1:0] lapo,
  input wire logic back_facing,
  input wire logic irq
);
  // ======================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RDATA_IDLE: assert property (ce && !rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_RDATA_RESULT: assert property (ce && rd && addr == 8'h28 |=> rdata ==
    {$past(orientation_changed_flag), $past(lockout), 3'b000, $past(lapo), $past(back_facing)})
    else $error("result read does not match reported state");
  AST_FLAG_HOLD: assert property (ce && orientation_changed_flag && !(rd && addr == 8'h28)
    |=> orientation_changed_flag) else $error("flag dropped without a read");
  AST_FLAG_CLEAR: assert property (ce && rd && addr == 8'h28 && !sample_tick
    |=> !orientation_changed_flag) else $error("flag not cleared by read");
  AST_FLAG_TICK: assert property ($rose(orientation_changed_flag)
    |-> $past(sample_tick) && $past(active)) else $error("flag rose without a sample");
  AST_HIGHG_HOLD: assert property (high_g && active && $past(active)
    |=> $stable({lockout, lapo, back_facing})) else $error("result moved under high g");
  AST_RESULT_ON_TICK: assert property (!sample_tick && active && $past(active)
    |=> $stable({lockout, lapo, back_facing})) else $error("result moved without a sample");
  AST_STANDBY_QUIET: assert property (!active |=> !$rose(orientation_changed_flag))
    else $error("flag rose in standby");
  AST_BACK_BAND: assert property ($rose(back_facing)
    |-> $past(z_angle) > 9'h064 && $past(z_angle) < 9'h104) else $error("back outside band");
  AST_FRONT_BAND: assert property ($fell(back_facing) && $past(active, 2)
    |-> $past(z_angle) < 9'h050 || $past(z_angle) > 9'h118) else $error("front outside band");
endmodule

// *** verif/testbench.sv ***
/*
  self-checking bench of the orientation settle block.
  assumes: design and checker compiled first; ce held high throughout.
*/
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [1:0] code;
    logic [8:0] z;
    logic [9:0] tilt;
    logic [1:0] li;
    logic [3:0] res;
  } row_t;
  logic clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, sample_tick = 0, active = 0;
  logic auto_sleep = 0, high_g = 0, orientation_changed_flag, lockout, back_facing, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
  logic [8:0] z_angle = 9'h000;
  logic [9:0] z_tilt_tenths = 10'h000;
  logic [1:0] lapo_class = 2'h0, lapo;
  logic [3:0] prev = 4'h0;
  int failures = 0, checks_done = 0;
  // res is {lockout, lapo, back}
  row_t rows [11] = '{'{2'h0, 9'h065, 10'h1f4, 2'h1, 4'h3}, '{2'h0, 9'h04f, 10'h1f4, 2'h2, 4'h4},
    '{2'h1, 9'h069, 10'h1f4, 2'h3, 4'h6}, '{2'h1, 9'h06a, 10'h1f4, 2'h3, 4'h7},
    '{2'h1, 9'h04b, 10'h1f4, 2'h0, 4'h1}, '{2'h2, 9'h045, 10'h1f4, 2'h0, 4'h0},
    '{2'h2, 9'h0fa, 10'h1f4, 2'h1, 4'h2}, '{2'h3, 9'h0f4, 10'h1f4, 2'h1, 4'h3},
    '{2'h3, 9'h128, 10'h1f4, 2'h2, 4'h4}, '{2'h1, 9'h128, 10'h118, 2'h3, 4'hc},
    '{2'h1, 9'h128, 10'h119, 2'h3, 4'h6}};
  logic [9:0] zth [8] = '{10'h088, 10'h0ab, 10'h0cf, 10'h0f4, 10'h119, 10'h140, 10'h169, 10'h194};

  orientation_settle orientation_settle_i (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sample_tick(sample_tick),
    .active(active), .auto_sleep(auto_sleep), .high_g(high_g), .z_angle(z_angle),
    .z_tilt_tenths(z_tilt_tenths), .lapo_class(lapo_class),
    .orientation_changed_flag(orientation_changed_flag), .lockout(lockout), .lapo(lapo),
    .back_facing(back_facing), .irq(irq));

  initial begin
    forever #25 clk = ~clk;
  end

  // ======================================
  // tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk);
      sample_tick <= 1'b1;
      @(posedge clk);
      sample_tick <= 1'b0;
    end
  endtask
  task automatic fl(input logic e);
    @(negedge clk);
    chk("flag_pin", {7'h00, e}, {7'h00, orientation_changed_flag});
    rreg(8'h28);
    chk("flag", {7'h00, e}, {7'h00, rv[7]});
  endtask
  task automatic ck_irq(input logic e);
    @(negedge clk);
    chk("irq", {7'h00, e}, {7'h00, irq});
  endtask
  task automatic setz(input logic [8:0] z);
    @(posedge clk);
    z_angle <= z;
  endtask
  task automatic flip_sleep();
    @(posedge clk);
    auto_sleep <= ~auto_sleep;
  endtask
  task automatic cls(input row_t r, input logic [2:0] zl);
    wreg(8'h2b, {r.code, 3'b000, zl});
    @(posedge clk);
    z_angle <= r.z;
    z_tilt_tenths <= r.tilt;
    lapo_class <= r.li;
    tk(2);
    rreg(8'h28);
    chk("result", {r.res != prev, r.res[3], 3'b000, r.res[2:0]}, rv);
    chk("pins", {4'h0, r.res}, {4'h0, lockout, lapo, back_facing});
    prev = r.res;
  endtask
  task automatic mrun(input logic m, input logic [8:0] y, input logic [8:0] g);
    wreg(8'h29, {m, 7'h40});
    wreg(8'h2a, 8'h04);
    flip_sleep();
    setz(y);
    tk(4);
    setz(g);
    tk(1);
    setz(y);
    tk(4);
    fl(!m);
    tk(1);
    fl(m);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    conclude();
  end

  // ======================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rreg(8'h29);
    chk("setup", 8'h80, rv);
    rreg(8'h2a);
    chk("settle", 8'h00, rv);
    rreg(8'h2b);
    chk("tilt", 8'h44, rv);
    rreg(8'h2c);
    chk("unmapped", 8'h00, rv);
    active <= 1'b1;
    setz(9'h0b4);
    tk(3);
    fl(1'b0);
    wreg(8'h29, 8'hc0);
    foreach (rows[i]) cls(rows[i], 3'h4);
    for (int i = 0; i < 8; i++) begin
      cls('{2'h1, 9'h128, zth[i] - 10'h001, 2'h3, 4'he}, 3'(i));
      cls('{2'h1, 9'h128, zth[i], 2'h3, 4'h6}, 3'(i));
    end
    wreg(8'h2a, 8'h03);
    setz(9'h0b4);
    tk(3);
    fl(1'b0);
    tk(1);
    fl(1'b1);
    mrun(1'b0, 9'h00a, 9'h0b4);
    mrun(1'b1, 9'h0b4, 9'h00a);
    wreg(8'h2a, 8'h02);
    setz(9'h00a);
    tk(1);
    high_g <= 1'b1;
    tk(3);
    fl(1'b0);
    high_g <= 1'b0;
    tk(1);
    fl(1'b0);
    tk(1);
    fl(1'b1);
    setz(9'h0b4);
    tk(2);
    flip_sleep();
    tk(1);
    fl(1'b0);
    tk(1);
    fl(1'b1);
    wreg(8'h2a, 8'h00);
    active <= 1'b0;
    setz(9'h00a);
    lapo_class <= 2'h0;
    active <= 1'b1;
    rreg(8'h28);
    chk("cleared", 8'h00, rv);
    tk(2);
    rreg(8'h28);
    chk("first", 8'h80, rv);
    rreg(8'h30);
    chk("status", 8'h01, rv);
    ck_irq(1'b0);
    wreg(8'h31, 8'h01);
    ck_irq(1'b1);
    wreg(8'h30, 8'h01);
    ck_irq(1'b0);
    conclude();
  end
endmodule

bind orientation_settle orientation_settle_sva orientation_settle_sva_i (.clk(clk),
  .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .sample_tick(sample_tick), .active(active), .auto_sleep(auto_sleep), .high_g(high_g),
  .z_angle(z_angle), .z_tilt_tenths(z_tilt_tenths), .lapo_class(lapo_class),
  .orientation_changed_flag(orientation_changed_flag), .lockout(lockout), .lapo(lapo),
  .back_facing(back_facing), .irq(irq));
